// ===== sirs_pkg.sv
// constants and types shared by the two-wire register slave
// assumes a register bank on the system clock side
package sirs_pkg;

  // -----------------------------------------------------------------
  // identification byte
  // -----------------------------------------------------------------
  localparam logic [4:0] SIRS_ID_PREFIX = 5'h15;

  // -----------------------------------------------------------------
  // byte framing, bit counter positions
  // -----------------------------------------------------------------
  localparam logic [3:0] SIRS_CNT_FIRST = 4'h0;
  localparam logic [3:0] SIRS_CNT_BYTE = 4'h8;
  localparam logic [3:0] SIRS_CNT_ACK = 4'h9;

  // -----------------------------------------------------------------
  // widths and reset values
  // -----------------------------------------------------------------
  localparam int SIRS_AW = 8;
  localparam int SIRS_DW = 8;
  localparam logic [7:0] SIRS_PTR_RST = 8'h00;
  localparam logic [7:0] SIRS_DATA_RST = 8'h00;

  // -----------------------------------------------------------------
  // power-up hold-off, counted in link clock cycles
  // -----------------------------------------------------------------
  localparam logic [5:0] SIRS_PWRUP_CYC = 6'h20;

  typedef enum logic [2:0] {
    SIRS_IDLE,
    SIRS_ID,
    SIRS_ADDR,
    SIRS_WDATA,
    SIRS_RDATA
  } sirs_state_type;

endpackage

// ===== sirs_slave.sv
// two-wire serial register slave: link side on LINK_CLK, register
// strobes on CLK; assumes REG_RDATA stands valid in the REG_RD cycle
// and that bus pull-ups resolve the open-drain data line
`timescale 1ns/1ps

// Notes on behaviour
// - slave only; master drives clock
// - bytes shift most significant bit first
// - id byte 10101, select pins, direction
// - two select pins give four addresses
// - id bit zero: one reads, zero writes
// - data edges while clock high are conditions
// - data pin released after power-up
// - ignore everything until a start
// - starts during power-up are ignored
// - stop returns port to idle
// - receiver pulls data low on ninth clock
// - acknowledge matching id and written bytes
// - write: id, address, data, each acknowledged
// - early stop discards the pending write
// - random read: address write, restart, id
// - keep sending while master acknowledges
// - pointer increments after acknowledged read
module sirs_slave (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic ADDR_SELECT_HIGH_PIN,
  input wire logic ADDR_SELECT_LOW_PIN,
  output logic [sirs_pkg::SIRS_AW-1:0] REG_ADDR,
  output logic [sirs_pkg::SIRS_DW-1:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire logic [sirs_pkg::SIRS_DW-1:0] REG_RDATA
);
  import sirs_pkg::*;

  // -----------------------------------------------------------------
  // link domain reset and pin synchronisers
  // -----------------------------------------------------------------
  logic lrst_meta_ff;
  logic lrst_n_ff;
  logic scl_meta_ff;
  logic scl_s_ff;
  logic scl_q_ff;
  logic sda_meta_ff;
  logic sda_s_ff;
  logic sda_q_ff;
  logic [1:0] sel_meta_ff;
  logic [1:0] sel_s_ff;
  logic ack_meta_ff;
  logic ack_s_ff;
  logic ack_q_ff;

  // pins and the reset come from other domains, two flops each
  always_ff @(posedge LINK_CLK) begin
    lrst_meta_ff <= RST_N;
    lrst_n_ff <= lrst_meta_ff;
    scl_meta_ff <= SCL_I;
    scl_s_ff <= scl_meta_ff;
    scl_q_ff <= scl_s_ff;
    sda_meta_ff <= SDA_I;
    sda_s_ff <= sda_meta_ff;
    sda_q_ff <= sda_s_ff;
    sel_meta_ff <= {ADDR_SELECT_HIGH_PIN, ADDR_SELECT_LOW_PIN};
    sel_s_ff <= sel_meta_ff;
  end

  // -----------------------------------------------------------------
  // bus condition detection
  // -----------------------------------------------------------------
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic ack_edge;

  // data edges with the clock high are only conditions
  assign start_det = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
  assign stop_det = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;
  // the master supplies every clock edge we act on
  assign scl_rise = scl_s_ff & ~scl_q_ff;
  assign scl_fall = ~scl_s_ff & scl_q_ff;
  assign ack_edge = ack_s_ff ^ ack_q_ff;

  // -----------------------------------------------------------------
  // link state machine
  // -----------------------------------------------------------------
  sirs_state_type state_ff;
  sirs_state_type nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] rx_ff;
  logic [7:0] nxt_rx;
  logic [7:0] tx_ff;
  logic [7:0] nxt_tx;
  logic oe_ff;
  logic nxt_oe;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic mack_ff;
  logic nxt_mack;
  logic rw_ff;
  logic nxt_rw;
  logic req_tgl_ff;
  logic nxt_req_tgl;
  logic req_wr_ff;
  logic nxt_req_wr;
  logic [7:0] req_addr_ff;
  logic [7:0] nxt_req_addr;
  logic [7:0] req_data_ff;
  logic [7:0] nxt_req_data;
  logic [7:0] rbuf_ff;
  logic [7:0] nxt_rbuf;
  logic [5:0] pwr_ff;
  logic [5:0] nxt_pwr;
  logic [7:0] rd_hold_ff;
  logic rd_ack_tgl_ff;
  logic powered;

  assign powered = (pwr_ff == SIRS_PWRUP_CYC);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_oe = oe_ff;
    nxt_ptr = ptr_ff;
    nxt_mack = mack_ff;
    nxt_rw = rw_ff;
    nxt_req_tgl = req_tgl_ff;
    nxt_req_wr = req_wr_ff;
    nxt_req_addr = req_addr_ff;
    nxt_req_data = req_data_ff;
    nxt_rbuf = rbuf_ff;
    nxt_pwr = pwr_ff;
    if (!powered) begin
      nxt_pwr = 6'(pwr_ff + 6'h01);
    end
    // hold register is stable once the answer toggle is seen
    if (ack_edge) begin
      nxt_rbuf = rd_hold_ff;
    end
    if (stop_det) begin
      // a write not yet issued is simply dropped
      nxt_state = SIRS_IDLE;
      nxt_oe = 1'b0;
    end else if (start_det && powered) begin
      // a repeated start keeps the pointer
      nxt_state = SIRS_ID;
      nxt_cnt = SIRS_CNT_FIRST;
      nxt_oe = 1'b0;
    end else if (state_ff != SIRS_IDLE) begin
      if (scl_rise) begin
        if (cnt_ff < SIRS_CNT_BYTE) begin
          nxt_rx = {rx_ff[6:0], sda_s_ff};
          nxt_cnt = 4'(cnt_ff + 4'h1);
        end else if (cnt_ff == SIRS_CNT_ACK &&
                     state_ff == SIRS_RDATA) begin
          nxt_mack = ~sda_s_ff;
        end
      end else if (scl_fall) begin
        if (cnt_ff == SIRS_CNT_BYTE) begin
          nxt_cnt = SIRS_CNT_ACK;
          case (state_ff)
            SIRS_ID: begin
              if (rx_ff[7:1] == {SIRS_ID_PREFIX, sel_s_ff}) begin
                nxt_oe = 1'b1;
                nxt_rw = rx_ff[0];
                if (rx_ff[0]) begin
                  // fetch from the current pointer
                  nxt_req_tgl = ~req_tgl_ff;
                  nxt_req_wr = 1'b0;
                  nxt_req_addr = ptr_ff;
                end
              end else begin
                nxt_state = SIRS_IDLE;
              end
            end
            SIRS_ADDR: begin
              nxt_oe = 1'b1;
            end
            SIRS_WDATA: begin
              nxt_oe = 1'b1;
            end
            SIRS_RDATA: begin
              // release for the master's slot and prefetch the next
              nxt_oe = 1'b0;
              nxt_req_tgl = ~req_tgl_ff;
              nxt_req_wr = 1'b0;
              nxt_req_addr = 8'(ptr_ff + 8'h01);
            end
            default: begin
              nxt_oe = 1'b0;
            end
          endcase
        end else if (cnt_ff == SIRS_CNT_ACK) begin
          nxt_cnt = SIRS_CNT_FIRST;
          nxt_oe = 1'b0;
          case (state_ff)
            SIRS_ID: begin
              if (rw_ff) begin
                nxt_state = SIRS_RDATA;
                nxt_tx = rbuf_ff;
                nxt_oe = ~rbuf_ff[7];
              end else begin
                nxt_state = SIRS_ADDR;
              end
            end
            SIRS_ADDR: begin
              nxt_ptr = rx_ff;
              nxt_state = SIRS_WDATA;
            end
            SIRS_WDATA: begin
              // only a fully acknowledged byte reaches the bank
              nxt_req_tgl = ~req_tgl_ff;
              nxt_req_wr = 1'b1;
              nxt_req_addr = ptr_ff;
              nxt_req_data = rx_ff;
              nxt_ptr = 8'(ptr_ff + 8'h01);
            end
            SIRS_RDATA: begin
              if (mack_ff) begin
                nxt_ptr = 8'(ptr_ff + 8'h01);
                nxt_tx = rbuf_ff;
                nxt_oe = ~rbuf_ff[7];
              end else begin
                nxt_state = SIRS_IDLE;
              end
            end
            default: begin
              nxt_state = SIRS_IDLE;
            end
          endcase
        end else if (state_ff == SIRS_RDATA &&
                     cnt_ff != SIRS_CNT_FIRST) begin
          // open drain: enable only to pull a zero low
          nxt_tx = {tx_ff[6:0], 1'b0};
          nxt_oe = ~tx_ff[6];
        end
      end
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n_ff) begin
      state_ff <= SIRS_IDLE;
      cnt_ff <= SIRS_CNT_FIRST;
      rx_ff <= SIRS_DATA_RST;
      tx_ff <= SIRS_DATA_RST;
      oe_ff <= 1'b0;
      ptr_ff <= SIRS_PTR_RST;
      mack_ff <= 1'b0;
      rw_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      req_wr_ff <= 1'b0;
      req_addr_ff <= SIRS_PTR_RST;
      req_data_ff <= SIRS_DATA_RST;
      rbuf_ff <= SIRS_DATA_RST;
      pwr_ff <= 6'h00;
      ack_meta_ff <= 1'b0;
      ack_s_ff <= 1'b0;
      ack_q_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      oe_ff <= nxt_oe;
      ptr_ff <= nxt_ptr;
      mack_ff <= nxt_mack;
      rw_ff <= nxt_rw;
      req_tgl_ff <= nxt_req_tgl;
      req_wr_ff <= nxt_req_wr;
      req_addr_ff <= nxt_req_addr;
      req_data_ff <= nxt_req_data;
      rbuf_ff <= nxt_rbuf;
      pwr_ff <= nxt_pwr;
      ack_meta_ff <= rd_ack_tgl_ff;
      ack_s_ff <= ack_meta_ff;
      ack_q_ff <= ack_s_ff;
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE = oe_ff;

  // -----------------------------------------------------------------
  // register side on CLK
  // -----------------------------------------------------------------
  logic rq_meta_ff;
  logic rq_s_ff;
  logic rq_q_ff;
  logic rq_ev;
  logic wr_ff;
  logic nxt_wr;
  logic rd_ff;
  logic nxt_rd;
  logic [7:0] addr_ff;
  logic [7:0] nxt_addr;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic [7:0] nxt_rd_hold;
  logic nxt_rd_ack_tgl;

  // request fields are held by the link until well after the toggle
  assign rq_ev = rq_s_ff ^ rq_q_ff;

  always_comb begin
    nxt_wr = rq_ev & req_wr_ff;
    nxt_rd = rq_ev & ~req_wr_ff;
    nxt_addr = rq_ev ? req_addr_ff : addr_ff;
    nxt_wdata = (rq_ev & req_wr_ff) ? req_data_ff : wdata_ff;
    nxt_rd_hold = rd_ff ? REG_RDATA : rd_hold_ff;
    nxt_rd_ack_tgl = rd_ff ? ~rd_ack_tgl_ff : rd_ack_tgl_ff;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rq_meta_ff <= 1'b0;
      rq_s_ff <= 1'b0;
      rq_q_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= SIRS_PTR_RST;
      wdata_ff <= SIRS_DATA_RST;
      rd_hold_ff <= SIRS_DATA_RST;
      rd_ack_tgl_ff <= 1'b0;
    end else begin
      rq_meta_ff <= req_tgl_ff;
      rq_s_ff <= rq_meta_ff;
      rq_q_ff <= rq_s_ff;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rd_hold_ff <= nxt_rd_hold;
      rd_ack_tgl_ff <= nxt_rd_ack_tgl;
    end
  end

  assign REG_ADDR = addr_ff;
  assign REG_WDATA = wdata_ff;
  assign REG_WR = wr_ff;
  assign REG_RD = rd_ff;

endmodule

// ===== sirs_props.sv
// assertion checker for the two-wire register slave ports
// assumes it is bound onto sirs_slave and sees only its ports
`timescale 1ns/1ps
module sirs_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic [sirs_pkg::SIRS_AW-1:0] REG_ADDR,
  input wire logic [sirs_pkg::SIRS_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD
);
  // -----------------------------------------------------------------
  // register strobe side
  // -----------------------------------------------------------------
  a_sdao_zero: assert property (
    @(posedge CLK) disable iff (!RST_N) SDA_O == 1'h0)
    else $error("open-drain data output not held low");
  a_wr_pulse: assert property (
    @(posedge CLK) disable iff (!RST_N) REG_WR |=> !REG_WR [*8])
    else $error("write strobe longer than one cycle or repeated");
  a_rd_pulse: assert property (
    @(posedge CLK) disable iff (!RST_N) REG_RD |=> !REG_RD [*8])
    else $error("read strobe longer than one cycle or repeated");
  a_strobe_excl: assert property (
    @(posedge CLK) disable iff (!RST_N) !(REG_WR && REG_RD))
    else $error("read and write strobes together");
  // the address may only move together with a strobe
  a_addr_held: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !REG_WR && !REG_RD |-> $stable(REG_ADDR))
    else $error("register address moved without a strobe");
  a_wdata_held: assert property (
    @(posedge CLK) disable iff (!RST_N) !REG_WR |-> $stable(REG_WDATA))
    else $error("write data moved without a write strobe");
  // -----------------------------------------------------------------
  // link side: data line only moves while the serial clock is low
  // -----------------------------------------------------------------
  a_oe_scl_high: assert property (
    @(posedge LINK_CLK) disable iff (!RST_N)
    SCL_I && $past(SCL_I) && $past(SCL_I, 2) && $past(SCL_I, 3)
    |-> $stable(SDA_OE)) else $error("data drive changed in clock high");
  a_oe_change_low: assert property (
    @(posedge LINK_CLK) disable iff (!RST_N)
    !$stable(SDA_OE) |-> !SCL_I && !$past(SCL_I))
    else $error("data drive changed near a clock rise");
endmodule

bind sirs_slave sirs_props u_sirs_props (
  .CLK(CLK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .SCL_I(SCL_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD)
);

// ===== sirs_master.sv
// bus master model: makes the serial clock and drives data open-drain
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module sirs_master (
  input wire logic link_clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_drv
);
  // -----------------------------------------------------------------
  // bus phases; the clock stands high between frames
  // -----------------------------------------------------------------
  localparam int HALF = 12;
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic half();
    repeat (HALF) @(negedge link_clk);
  endtask
  // a repeated start first raises data while the clock is low
  task automatic start();
    if (!scl) begin
      sda_drv = 1'h1;
      half();
      scl = 1'h1;
      half();
    end
    sda_drv = 1'h0;
    half();
    scl = 1'h0;
  endtask
  task automatic stop();
    sda_drv = 1'h0;
    half();
    scl = 1'h1;
    half();
    sda_drv = 1'h1;
    half();
  endtask
  // sampled at the end of the high phase, where the slave has settled
  task automatic bit_xfer(input logic b, output logic r);
    sda_drv = b;
    half();
    scl = 1'h1;
    half();
    r = sda_in;
    scl = 1'h0;
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'h1, r);
    ack = !r;
  endtask
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'h1, d[i]);
    bit_xfer(!ack, r);
  endtask
endmodule

// ===== test_sirs_slave.sv
// self-checking bench for the two-wire register slave
// assumes a bank model on the system clock and the bus master model
`timescale 1ns/1ps
module test_sirs_slave;
  import sirs_pkg::*;
  typedef struct packed {
    logic hi;
    logic lo;
    logic [7:0] ra;
    logic [7:0] wd;
  } sirs_row_type;
  logic clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst_n = 1'h0;
  logic sel_hi = 1'h0;
  logic sel_lo = 1'h0;
  logic [7:0] reg_rdata;
  logic scl, sda_drv, sda, sda_o, sda_oe, reg_wr, reg_rd, a;
  logic [7:0] reg_addr, reg_wdata, d, id;
  logic [7:0] mem [256];
  int n_fail = 0;
  int num_checks = 0;
  sirs_row_type rows [4] = '{'{1'h0, 1'h0, 8'h10, 8'h3c},
    '{1'h0, 1'h1, 8'h21, 8'ha5}, '{1'h1, 1'h0, 8'hfe, 8'h01},
    '{1'h1, 1'h1, 8'h7f, 8'hc3}};
  always #10 clk = ~clk;
  always begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  assign sda = (sda_oe ? sda_o : 1'h1) & sda_drv;
  sirs_slave u_sirs_slave (.CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .ADDR_SELECT_HIGH_PIN(sel_hi), .ADDR_SELECT_LOW_PIN(sel_lo),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
  sirs_master u_sirs_master (.link_clk(link_clk), .sda_in(sda),
    .scl(scl), .sda_drv(sda_drv));
  // bank data stands in the read strobe's own cycle, no wait states
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge clk) begin
    if (reg_wr) mem[reg_addr] <= reg_wdata;
  end
  assign reg_rdata = mem[reg_addr];
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic ack_tx(input logic [7:0] b);
    u_sirs_master.tx(b, a);
    check(8'(a), 8'h01);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    u_sirs_master.start();
    ack_tx(id);
    ack_tx(ra);
    ack_tx(wd);
    u_sirs_master.stop();
  endtask
  task automatic rd(input logic [7:0] ra, input logic set_ptr, input int n,
    input logic [7:0] e0);
    if (set_ptr) begin
      u_sirs_master.start();
      ack_tx(id);
      ack_tx(ra);
    end
    u_sirs_master.start();
    ack_tx(id | 8'h01);
    for (int k = 0; k < n; k++) begin
      u_sirs_master.rx(k < n - 1, d);
      check(d, k == 0 ? e0 : 8'(ra + k) ^ 8'h5a);
    end
    u_sirs_master.stop();
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    check({7'h0, sda_oe}, 8'h00);
    check({6'h0, reg_wr, reg_rd}, 8'h00);
    check(reg_addr, SIRS_PTR_RST);
    rst_n = 1'h1;
    u_sirs_master.start();
    u_sirs_master.tx(8'ha8, a);
    check(8'(a), 8'h00);
    u_sirs_master.stop();
    foreach (rows[i]) begin
      @(negedge clk);
      sel_hi = rows[i].hi;
      sel_lo = rows[i].lo;
      id = {SIRS_ID_PREFIX, rows[i].hi, rows[i].lo, 1'h0};
      wr(rows[i].ra, rows[i].wd);
      check(mem[rows[i].ra], rows[i].wd);
      rd(rows[i].ra, 1'h1, 3, rows[i].wd);
    end
    rd(8'h81, 1'h0, 1, 8'h81 ^ 8'h5a);
    // reset in mid-run: pointer back to its reset value
    @(negedge clk);
    rst_n = 1'h0;
    repeat (4) @(negedge clk);
    check({7'h0, sda_oe}, 8'h00);
    check(reg_addr, SIRS_PTR_RST);
    rst_n = 1'h1;
    repeat (16) @(negedge clk);
    rd(8'h00, 1'h0, 1, SIRS_PTR_RST ^ 8'h5a);
    u_sirs_master.start();
    u_sirs_master.tx({SIRS_ID_PREFIX, 2'h1, 1'h0}, a);
    check(8'(a), 8'h00);
    u_sirs_master.tx(8'h40, a);
    check(8'(a), 8'h00);
    u_sirs_master.stop();
    u_sirs_master.start();
    ack_tx(id);
    ack_tx(8'h40);
    repeat (4) u_sirs_master.bit_xfer(1'h0, a);
    u_sirs_master.stop();
    repeat (8) @(negedge clk);
    check(mem[8'h40], 8'h40 ^ 8'h5a);
    wr(8'h41, 8'h99);
    check(mem[8'h41], 8'h99);
    finish_test();
  end
endmodule
